// [common/irq_front_defines.vh]
// Offsets, fields, reset values and codes of the interrupt front end
`ifndef IRQ_FRONT_DEFINES_VH
`define IRQ_FRONT_DEFINES_VH

// ==================================================
// Register byte offsets
`define OFS_CONTROL 12'h000
`define OFS_SENSE 12'h004
`define OFS_ENABLE 12'h008
`define OFS_STATUS 12'h00c
`define OFS_PRIO_A 12'h010
`define OFS_PRIO_B 12'h014
`define OFS_PRIO_C 12'h018
`define OFS_PRIO_D 12'h01c
`define OFS_PRIO_F 12'h020
`define OFS_WAKE 12'h024
`define OFS_SELECT 12'h028

// ==================================================
// Field positions
`define CTL_MODE2_BIT 0
`define CTL_NMI_EDGE_BIT 3
`define CONV_BIT 16
`define NMI_STAT_BIT 17
`define CONV_PRIO_LSB 8

// ==================================================
// Reset values
`define CONTROL_RST 2'h0
`define SENSE_RST 32'h0000_0000
`define ENABLE_RST 17'h0_0000
`define PRIO_RST 16'h7777
`define WAKE_RST 16'h0000

// ==================================================
// Sense codes
`define SENSE_LOW 2'h0
`define SENSE_FALL 2'h1
`define SENSE_RISE 2'h2
`define SENSE_BOTH 2'h3

// ==================================================
// Vector numbers
`define VEC_NMI 8'h07
`define VEC_LINE0 8'h10
`define VEC_CONV0 8'h26

`endif

// [rtl/irq_line_detect.v]
// Synchroniser and sense detector for one external request line
`timescale 1ns/100ps
`include "irq_front_defines.vh"

module irq_line_detect (
	input wire i_clk,
	input wire i_resetn,
	input wire i_pin,
	input wire [1:0] i_sense,
	input wire i_sample_en,
	output wire o_hit,
	output wire o_pin_high
);

reg meta_r;
reg sync_r;
reg prev_r;
wire fall;
wire rise;
reg hit;

// ==================================================
// Synchroniser
// two-stage sync first
always @(posedge i_clk or negedge i_resetn) begin
	if (!i_resetn) begin
		meta_r <= 1'b1;
		sync_r <= 1'b1;
		prev_r <= 1'b1;
	end else begin
		meta_r <= i_pin;
		sync_r <= meta_r;
		prev_r <= sync_r;
	end
end

assign fall = prev_r & ~sync_r;
assign rise = ~prev_r & sync_r;

// ==================================================
// Detection
// sense code decode
always @* begin
	case (i_sense)
	`SENSE_LOW: hit = ~sync_r;
	`SENSE_FALL: hit = fall;
	`SENSE_RISE: hit = rise;
	default: hit = fall | rise;
	endcase
end

assign o_hit = hit & i_sample_en;
assign o_pin_high = sync_r;

endmodule // irq_line_detect

// [rtl/irq_front.v]
// External and internal interrupt front end with APB registers
// Function
// - Wake bit gates standby sampling, requests wake
// - NMI plus sixteen numbered request lines
// - NMI highest, forwarded regardless of mask
// - Edge select bit picks NMI rising/falling
// - Lines sense low, fall, rise, both
// - Enabled lines only reach arbitration
// - Per-line pending flag, software clearable
// - Detection uses pin level regardless direction
// - Internal source flag and enable, independent
// - Transfer/DMA starts ignore mode and mask
// - Default order: lower vector wins
// - Mode 2 uses levels, ties default order
// - NMI vector 7, address 1C
// - Line n vector 16+n, fields per register
// - Lines start transfer only; converter both
// - Sense code 00/01/10/11 meaning
// - Clear by read-1-write-0 or exception handling
// - Mode 2 accepts only above mask level
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "irq_front_defines.vh"

module irq_front (
	input wire I_CLK,
	input wire I_RESETN,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [11:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	output wire [31:0] O_PRDATA,
	output wire O_PREADY,
	output wire O_PSLVERR,
	input wire I_NMI_PIN,
	input wire [15:0] I_IRQ_PIN,
	input wire I_CONV_DONE,
	input wire I_STANDBY,
	input wire I_CPU_I_BIT,
	input wire [2:0] I_MASK_LEVEL,
	input wire I_ACK,
	input wire [7:0] I_ACK_VECTOR,
	output wire O_NMI_REQ,
	output wire O_INT_REQ,
	output wire [7:0] O_INT_VECTOR,
	output wire [15:0] O_INT_VEC_ADDR,
	output wire [2:0] O_INT_LEVEL,
	output wire [16:0] O_DTC_REQ,
	output wire O_DMA_REQ,
	output wire O_WAKE_REQ
);

// ==================================================
// Declarations
reg mode2_r;
reg nmi_edge_r;
reg [31:0] sense_r;
reg [16:0] enable_r;
reg [15:0] prio_a_r;
reg [15:0] prio_b_r;
reg [15:0] prio_c_r;
reg [15:0] prio_d_r;
reg [15:0] prio_f_r;
reg [15:0] wake_r;
reg [16:0] flag_r;
reg [16:0] flag_nxt;
reg [16:0] seen_r;
reg nmi_flag_r;
reg nmi_meta_r;
reg nmi_sync_r;
reg nmi_prev_r;
reg [31:0] rdata_r;
reg slverr_r;
reg int_req_r;
reg [7:0] int_vec_r;
reg [2:0] int_lvl_r;
reg nmi_req_r;
reg [16:0] dtc_req_r;
reg dma_req_r;
reg wake_req_r;
reg [31:0] rd_mux;
reg rd_bad;
reg [16:0] clr_sw;
reg [16:0] clr_ack;
reg found;
reg [4:0] best;
reg [2:0] best_lvl;
reg accept;
reg [7:0] sel_vec;
reg [2:0] sel_lvl;
wire [15:0] line_hit;
wire [15:0] pin_high;
wire [15:0] sample_en;
wire [16:0] set_now;
wire [16:0] pend;
wire [47:0] line_lvl;
wire [50:0] src_lvl;
wire nmi_hit;
wire setup;
wire wr_acc;
wire rd_acc;
integer i, j;

assign setup = I_PSEL & ~I_PENABLE;
assign wr_acc = I_PSEL & I_PENABLE & I_PWRITE;
assign rd_acc = I_PSEL & I_PENABLE & ~I_PWRITE;

// ==================================================
// Line detectors
genvar g;
generate
	for (g = 0; g < 16; g = g + 1) begin : line
		assign sample_en[g] = ~I_STANDBY | wake_r[g];
		irq_line_detect u_det (
			.i_clk(I_CLK),
			.i_resetn(I_RESETN),
			.i_pin(I_IRQ_PIN[g]),
			.i_sense(sense_r[2*g+1:2*g]),
			.i_sample_en(sample_en[g]),
			.o_hit(line_hit[g]),
			.o_pin_high(pin_high[g])
		);
	end
endgenerate

// Pin level is sampled directly, so port direction has no say
// detection from pin level
assign set_now = {I_CONV_DONE, line_hit};

// ==================================================
// NMI edge detection
always @(posedge I_CLK or negedge I_RESETN) begin
	if (!I_RESETN) begin
		nmi_meta_r <= 1'b1;
		nmi_sync_r <= 1'b1;
		nmi_prev_r <= 1'b1;
	end else begin
		nmi_meta_r <= I_NMI_PIN;
		nmi_sync_r <= nmi_meta_r;
		nmi_prev_r <= nmi_sync_r;
	end
end

assign nmi_hit = nmi_edge_r ? (~nmi_prev_r & nmi_sync_r) :
	(nmi_prev_r & ~nmi_sync_r);

always @(posedge I_CLK or negedge I_RESETN) begin
	if (!I_RESETN) begin
		nmi_flag_r <= 1'b0;
	end else if (nmi_hit) begin
		nmi_flag_r <= 1'b1;
	end else if (I_ACK && I_ACK_VECTOR == `VEC_NMI) begin
		nmi_flag_r <= 1'b0;
	end
end

// ==================================================
// Pending flags
always @* begin
	clr_sw = 17'h0_0000;
	clr_ack = 17'h0_0000;
	if (wr_acc && I_PADDR == `OFS_STATUS) begin
		clr_sw = seen_r & ~I_PWDATA[16:0];
	end
	for (i = 0; i < 16; i = i + 1) begin
		if (I_ACK && I_ACK_VECTOR == `VEC_LINE0 + i[7:0] &&
			(sense_r[2*i+:2] != `SENSE_LOW || pin_high[i])) begin
			clr_ack[i] = 1'b1;
		end
	end
	if (I_ACK && I_ACK_VECTOR == `VEC_CONV0) begin
		clr_ack[`CONV_BIT] = 1'b1;
	end
	flag_nxt = (flag_r & ~clr_sw & ~clr_ack) | set_now;
end

always @(posedge I_CLK or negedge I_RESETN) begin
	if (!I_RESETN) begin
		flag_r <= 17'h0_0000;
		seen_r <= 17'h0_0000;
	end else begin
		flag_r <= flag_nxt;
		if (rd_acc && I_PADDR == `OFS_STATUS) begin
			seen_r <= seen_r | rdata_r[16:0];
		end else if (wr_acc && I_PADDR == `OFS_STATUS) begin
			seen_r <= seen_r & ~clr_sw;
		end
	end
end

assign pend = flag_r & enable_r;

// ==================================================
// Priority fields
// line n uses next 3-bit field
assign line_lvl = {prio_d_r[2:0], prio_d_r[6:4], prio_d_r[10:8],
	prio_d_r[14:12], prio_c_r[2:0], prio_c_r[6:4], prio_c_r[10:8],
	prio_c_r[14:12], prio_b_r[2:0], prio_b_r[6:4], prio_b_r[10:8],
	prio_b_r[14:12], prio_a_r[2:0], prio_a_r[6:4], prio_a_r[10:8],
	prio_a_r[14:12]};
assign src_lvl = {prio_f_r[`CONV_PRIO_LSB+2:`CONV_PRIO_LSB], line_lvl};

// ==================================================
// Arbitration
always @* begin
	found = 1'b0;
	best = 5'h00;
	best_lvl = 3'h0;
	for (j = 0; j < 17; j = j + 1) begin
		if (pend[j]) begin
			if (!found ||
				(mode2_r && src_lvl[3*j+:3] > best_lvl)) begin
				found = 1'b1;
				best = j[4:0];
				best_lvl = src_lvl[3*j+:3];
			end
		end
	end
	// mode 2 needs level above mask
	if (mode2_r) begin
		accept = found && (best_lvl > I_MASK_LEVEL);
	end else begin
		accept = found && !I_CPU_I_BIT;
	end
	if (best == 5'h10) begin
		sel_vec = `VEC_CONV0;
	end else begin
		sel_vec = `VEC_LINE0 + {4'h0, best[3:0]};
	end
	sel_lvl = mode2_r ? best_lvl : 3'h0;
	if (nmi_flag_r) begin
		accept = 1'b1;
		sel_vec = `VEC_NMI;
		sel_lvl = 3'h7;
	end
end

always @(posedge I_CLK or negedge I_RESETN) begin
	if (!I_RESETN) begin
		int_req_r <= 1'b0;
		int_vec_r <= 8'h00;
		int_lvl_r <= 3'h0;
		nmi_req_r <= 1'b0;
		dtc_req_r <= 17'h0_0000;
		dma_req_r <= 1'b0;
		wake_req_r <= 1'b0;
	end else begin
		int_req_r <= accept;
		int_vec_r <= sel_vec;
		int_lvl_r <= sel_lvl;
		nmi_req_r <= nmi_flag_r;
		dtc_req_r <= pend;
		dma_req_r <= pend[`CONV_BIT];
		// Oscillator settling is timed by the clock unit on this
		// wake from pending line with its wake bit set
		wake_req_r <= I_STANDBY & |(flag_r[15:0] & wake_r);
	end
end

assign O_NMI_REQ = nmi_req_r;
assign O_INT_REQ = int_req_r;
assign O_INT_VECTOR = int_vec_r;
assign O_INT_VEC_ADDR = {6'h00, int_vec_r, 2'h0};
assign O_INT_LEVEL = int_lvl_r;
assign O_DTC_REQ = dtc_req_r;
assign O_DMA_REQ = dma_req_r;
assign O_WAKE_REQ = wake_req_r;

// ==================================================
// APB register writes
always @(posedge I_CLK or negedge I_RESETN) begin
	if (!I_RESETN) begin
		mode2_r <= 1'b0;
		nmi_edge_r <= 1'b0;
		sense_r <= `SENSE_RST;
		enable_r <= `ENABLE_RST;
		prio_a_r <= `PRIO_RST;
		prio_b_r <= `PRIO_RST;
		prio_c_r <= `PRIO_RST;
		prio_d_r <= `PRIO_RST;
		prio_f_r <= `PRIO_RST;
		wake_r <= `WAKE_RST;
	end else if (wr_acc) begin
		if (I_PADDR == `OFS_CONTROL) begin
			mode2_r <= I_PWDATA[`CTL_MODE2_BIT];
			nmi_edge_r <= I_PWDATA[`CTL_NMI_EDGE_BIT];
		end else if (I_PADDR == `OFS_SENSE) begin
			sense_r <= I_PWDATA;
		end else if (I_PADDR == `OFS_ENABLE) begin
			enable_r <= I_PWDATA[16:0];
		end else if (I_PADDR == `OFS_PRIO_A) begin
			prio_a_r <= I_PWDATA[15:0] & 16'h7777;
		end else if (I_PADDR == `OFS_PRIO_B) begin
			prio_b_r <= I_PWDATA[15:0] & 16'h7777;
		end else if (I_PADDR == `OFS_PRIO_C) begin
			prio_c_r <= I_PWDATA[15:0] & 16'h7777;
		end else if (I_PADDR == `OFS_PRIO_D) begin
			prio_d_r <= I_PWDATA[15:0] & 16'h7777;
		end else if (I_PADDR == `OFS_PRIO_F) begin
			prio_f_r <= I_PWDATA[15:0] & 16'h7777;
		end else if (I_PADDR == `OFS_WAKE) begin
			wake_r <= I_PWDATA[15:0];
		end
	end
end

// ==================================================
// APB read decode
always @* begin
	rd_mux = 32'h0000_0000;
	rd_bad = 1'b0;
	if (I_PADDR == `OFS_CONTROL) begin
		rd_mux[`CTL_MODE2_BIT] = mode2_r;
		rd_mux[`CTL_NMI_EDGE_BIT] = nmi_edge_r;
	end else if (I_PADDR == `OFS_SENSE) begin
		rd_mux = sense_r;
	end else if (I_PADDR == `OFS_ENABLE) begin
		rd_mux[16:0] = enable_r;
	end else if (I_PADDR == `OFS_STATUS) begin
		rd_mux[16:0] = flag_r;
		rd_mux[`NMI_STAT_BIT] = nmi_flag_r;
	end else if (I_PADDR == `OFS_PRIO_A) begin
		rd_mux[15:0] = prio_a_r;
	end else if (I_PADDR == `OFS_PRIO_B) begin
		rd_mux[15:0] = prio_b_r;
	end else if (I_PADDR == `OFS_PRIO_C) begin
		rd_mux[15:0] = prio_c_r;
	end else if (I_PADDR == `OFS_PRIO_D) begin
		rd_mux[15:0] = prio_d_r;
	end else if (I_PADDR == `OFS_PRIO_F) begin
		rd_mux[15:0] = prio_f_r;
	end else if (I_PADDR == `OFS_WAKE) begin
		rd_mux[15:0] = wake_r;
	end else if (I_PADDR == `OFS_SELECT) begin
		rd_mux = {20'h0_0000, int_req_r, int_lvl_r, int_vec_r};
	end else begin
		rd_bad = 1'b1;
	end
end

// Read data is caught in setup so the access phase needs no wait
always @(posedge I_CLK or negedge I_RESETN) begin
	if (!I_RESETN) begin
		rdata_r <= 32'h0000_0000;
		slverr_r <= 1'b0;
	end else if (setup) begin
		rdata_r <= I_PWRITE ? 32'h0000_0000 : rd_mux;
		slverr_r <= rd_bad;
	end
end

assign O_PRDATA = rdata_r;
assign O_PREADY = 1'b1;
assign O_PSLVERR = I_PSEL & I_PENABLE & slverr_r;

endmodule // irq_front

// [verification/irq_src_model.sv]
// Behavioural external request sources driving the pins
`timescale 1ns/100ps
module irq_src_model (
	input wire i_clk,
	input wire i_resetn,
	input wire [15:0] i_drop,
	input wire [15:0] i_raise,
	input wire i_ack,
	input wire [7:0] i_ack_vector,
	output logic [15:0] o_pin
);
	integer n;
	// ==========
	// Source lines, idle high
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			o_pin <= 16'hffff;
		else
			for (n = 0; n < 16; n = n + 1)
				if (i_drop[n])
					o_pin[n] <= 1'b0;
				else if (i_raise[n] || (i_ack && i_ack_vector == n + 16))
					o_pin[n] <= 1'b1;
	end
endmodule // irq_src_model

// [verification/irq_front_chk.sv]
// Port assertions for the interrupt front end
`timescale 1ns/100ps
module irq_front_chk (
	input wire I_CLK,
	input wire I_RESETN,
	input wire I_STANDBY,
	input wire [2:0] I_MASK_LEVEL,
	input wire O_NMI_REQ,
	input wire O_INT_REQ,
	input wire [7:0] O_INT_VECTOR,
	input wire [15:0] O_INT_VEC_ADDR,
	input wire [2:0] O_INT_LEVEL,
	input wire [16:0] O_DTC_REQ,
	input wire O_DMA_REQ,
	input wire O_WAKE_REQ
);
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RESETN);
	// ==========
	// Assertions
	rst_quiet_a: assert property (disable iff (1'b0)
		!I_RESETN |-> !O_INT_REQ && !O_NMI_REQ && O_DTC_REQ == 17'h0)
		else $error("Request in reset");
	vec_addr_a: assert property (
		O_INT_REQ |-> O_INT_VEC_ADDR == {6'h00, O_INT_VECTOR, 2'h0})
		else $error("Bad vector address");
	nmi_vec_a: assert property (
		O_INT_REQ && O_INT_VECTOR == 8'h07 |->
		O_INT_VEC_ADDR == 16'h001c && O_INT_LEVEL == 3'h7)
		else $error("Bad nonmaskable vector");
	nmi_first_a: assert property (
		O_NMI_REQ && $past(O_NMI_REQ) |-> O_INT_REQ && O_INT_VECTOR == 8'h07)
		else $error("Nonmaskable not first");
	vec_set_a: assert property (
		O_INT_REQ |-> O_INT_VECTOR inside {8'h07, [8'h10:8'h1f], 8'h26})
		else $error("Unknown source vector");
	dma_conv_a: assert property (
		O_DMA_REQ |-> O_DTC_REQ[16])
		else $error("DMA start without converter");
	wake_stby_a: assert property (
		O_WAKE_REQ |-> $past(I_STANDBY))
		else $error("Wake outside standby");
	mask_cmp_a: assert property (
		O_INT_REQ && !O_NMI_REQ && O_INT_LEVEL != 3'h0 &&
		$stable(I_MASK_LEVEL) && $past(I_MASK_LEVEL, 2) == I_MASK_LEVEL
		|-> O_INT_LEVEL > I_MASK_LEVEL)
		else $error("Level not above mask");
	nmi_c: cover property (O_NMI_REQ && O_INT_REQ);
	lvl_c: cover property (O_INT_REQ && O_INT_LEVEL == 3'h5);
	dma_c: cover property (O_DMA_REQ);
endmodule // irq_front_chk

bind irq_front irq_front_chk i_chk (
	.I_CLK(I_CLK),
	.I_RESETN(I_RESETN),
	.I_STANDBY(I_STANDBY),
	.I_MASK_LEVEL(I_MASK_LEVEL),
	.O_NMI_REQ(O_NMI_REQ),
	.O_INT_REQ(O_INT_REQ),
	.O_INT_VECTOR(O_INT_VECTOR),
	.O_INT_VEC_ADDR(O_INT_VEC_ADDR),
	.O_INT_LEVEL(O_INT_LEVEL),
	.O_DTC_REQ(O_DTC_REQ),
	.O_DMA_REQ(O_DMA_REQ),
	.O_WAKE_REQ(O_WAKE_REQ)
);

// [verification/external_irq_vector_priority_tb.sv]
// Self-checking bench for the interrupt front end
`timescale 1ns/100ps
`include "irq_front_defines.vh"
module external_irq_vector_priority_tb;
	// Reset starts high so the first reset gives a real falling edge
	logic clk = 1'b0, resetn = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic nmi = 1'b1, conv = 1'b0, stby = 1'b0, ibit = 1'b0, ack = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [2:0] mask = 3'h0, lvl;
	logic [7:0] ackv = 8'h00, vec;
	logic [15:0] drop = 16'h0, rise = 16'h0, pins, vaddr;
	logic [16:0] data_transfer_controller;
	logic pready, perr, e, nreq, ireq, dma, wake;
	int fails = 0, n_checks = 0;
	always #2 clk = ~clk;
	irq_src_model i_src (.i_clk(clk), .i_resetn(resetn), .i_drop(drop),
		.i_raise(rise), .i_ack(ack), .i_ack_vector(ackv), .o_pin(pins));
	irq_front i_dut (.I_CLK(clk), .I_RESETN(resetn), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(perr),
		.I_NMI_PIN(nmi), .I_IRQ_PIN(pins), .I_CONV_DONE(conv),
		.I_STANDBY(stby), .I_CPU_I_BIT(ibit), .I_MASK_LEVEL(mask),
		.I_ACK(ack), .I_ACK_VECTOR(ackv), .O_NMI_REQ(nreq), .O_INT_REQ(ireq),
		.O_INT_VECTOR(vec), .O_INT_VEC_ADDR(vaddr), .O_INT_LEVEL(lvl),
		.O_DTC_REQ(data_transfer_controller), .O_DMA_REQ(dma), .O_WAKE_REQ(wake));
	// ==========
	// Shared tasks
	// Wide enough for the flag and data pairs that scenarios compare
	task chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q = prdata;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	task pulse(input logic [15:0] m, input logic up);
		if (up)
			rise <= m;
		else
			drop <= m;
		@(posedge clk);
		rise <= 16'h0;
		drop <= 16'h0;
		cyc(8);
	endtask
	task rst;
		resetn <= 1'b0;
		ibit <= 1'b0;
		mask <= 3'h0;
		cyc(5);
		resetn <= 1'b1;
		@(posedge clk);
	endtask
	// ==========
	// Scenarios
	task t_regs;
		apb(0, `OFS_PRIO_A, 0);
		chk(q, {16'h0, `PRIO_RST});
		apb(1, `OFS_PRIO_B, 32'hffff_ffff);
		apb(0, `OFS_PRIO_B, 0);
		chk(q, 32'h7777);
		apb(0, `OFS_WAKE, 0);
		chk(q, 32'h0);
		apb(1, `OFS_WAKE, 32'h0001_ffff);
		apb(0, `OFS_WAKE, 0);
		chk(q, 32'hffff);
		apb(0, 12'h100, 0);
		chk({e, q}, 33'h1_0000_0000);
		$display("register test done");
	endtask
	task t_sense;
		rst;
		apb(1, `OFS_SENSE, 32'he4);
		apb(1, `OFS_ENABLE, 32'h2);
		pulse(16'hf, 0);
		apb(0, `OFS_STATUS, 0);
		chk(q, 32'hb);
		chk({ireq, vec}, {1'b1, 8'h11});
		apb(1, `OFS_STATUS, 0);
		apb(0, `OFS_STATUS, 0);
		chk(q, 32'h1);
		pulse(16'hf, 1);
		apb(1, `OFS_STATUS, 0);
		apb(0, `OFS_STATUS, 0);
		chk(q, 32'hc);
		apb(1, `OFS_STATUS, 0);
		apb(0, `OFS_STATUS, 0);
		chk({ireq, q}, 33'h0);
		$display("sense test done");
	endtask
	task t_prio;
		rst;
		apb(1, `OFS_SENSE, 32'h5);
		apb(1, `OFS_ENABLE, 32'h3);
		ibit <= 1'b1;
		pulse(16'h3, 0);
		chk({ireq, dma, data_transfer_controller}, 19'h3);
		ibit <= 1'b0;
		cyc(3);
		chk({ireq, vec}, {1'b1, 8'h10});
		apb(1, `OFS_PRIO_A, 32'h3500);
		apb(1, `OFS_CONTROL, 32'h1);
		mask <= 3'h5;
		cyc(3);
		chk(ireq, 0);
		mask <= 3'h4;
		cyc(3);
		chk({ireq, lvl, vec}, {1'b1, 3'h5, 8'h11});
		apb(1, `OFS_PRIO_A, 32'h5500);
		cyc(3);
		chk({ireq, lvl, vec}, {1'b1, 3'h5, 8'h10});
		apb(0, `OFS_SELECT, 0);
		chk(q, 32'h0000_0d10);
		ack <= 1'b1;
		ackv <= 8'h10;
		@(posedge clk);
		ack <= 1'b0;
		cyc(3);
		chk({ireq, vec}, {1'b1, 8'h11});
		$display("priority test done");
	endtask
	task t_conv;
		rst;
		conv <= 1'b1;
		@(posedge clk);
		conv <= 1'b0;
		cyc(3);
		chk({dma, data_transfer_controller}, 0);
		apb(1, `OFS_ENABLE, 32'h1_0000);
		cyc(2);
		chk({dma, ireq, vec, data_transfer_controller}, {2'h3, 8'h26, 17'h1_0000});
		ack <= 1'b1;
		ackv <= 8'h26;
		@(posedge clk);
		ack <= 1'b0;
		cyc(3);
		chk(dma, 0);
		$display("converter test done");
	endtask
	task t_wake;
		rst;
		apb(1, `OFS_WAKE, 32'h4);
		stby <= 1'b1;
		pulse(16'hc, 0);
		chk(wake, 1);
		apb(0, `OFS_STATUS, 0);
		chk(q, 32'h4);
		stby <= 1'b0;
		$display("wake test done");
	endtask
	task t_nmi;
		rst;
		apb(1, `OFS_CONTROL, 32'h8);
		ibit <= 1'b1;
		nmi <= 1'b0;
		cyc(8);
		chk(nreq, 0);
		nmi <= 1'b1;
		cyc(8);
		chk({ireq, nreq, vaddr}, {2'h3, 16'h001c});
		ack <= 1'b1;
		ackv <= 8'h07;
		@(posedge clk);
		ack <= 1'b0;
		cyc(3);
		chk(nreq, 0);
		apb(1, `OFS_CONTROL, 0);
		nmi <= 1'b0;
		cyc(8);
		chk({ireq, nreq}, 2'h3);
		$display("nonmaskable test done");
	endtask
	task wrap_up;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		rst;
		t_regs;
		t_sense;
		t_prio;
		t_conv;
		t_wake;
		t_nmi;
		wrap_up;
	end
	// Whole run is a few hundred cycles
	initial begin
		#20000;
		fails++;
		wrap_up;
	end
endmodule // external_irq_vector_priority_tb
